// ### logic/beam_pkg.sv
// Shared constants for the broadcast pattern and top control block.
// Assumes a single clock that stands in for the pattern master clock.
package beam_pkg;

  // Register addresses as seen by the decoded serial-interface write port.
  localparam logic [5:0] ADDR_CHAN_POS_BASE   = 6'h08;
  localparam logic [5:0] ADDR_CHAN_NEG_BASE   = 6'h10;
  localparam logic [5:0] ADDR_BCAST_POS       = 6'h18;
  localparam logic [5:0] ADDR_BCAST_NEG       = 6'h19;
  localparam logic [5:0] ADDR_TOP_CTRL        = 6'h1A;

  // Widths.
  localparam int         PAT_W                = 64;
  localparam int         CTRL_W               = 14;
  localparam int         MAX_CHANNELS         = 8;

  // Reset values of the pattern and control registers.
  localparam logic [63:0] POS_PATTERN_RESET   = 64'h0000_5555_5555_5555;
  localparam logic [63:0] NEG_PATTERN_RESET   = 64'hAAAA_AAAA_AAAA_AAAA;
  localparam logic [13:0] TOP_CTRL_RESET      = 14'h047F;

  // Field positions inside the top control register.
  localparam int         CTRL_RSV_BIT         = 13;
  localparam int         CTRL_CW_BIT          = 12;
  localparam int         CTRL_IFE_BIT         = 11;
  localparam int         CTRL_PLL_BIT         = 10;
  localparam int         CTRL_FD_MSB          = 9;
  localparam int         CTRL_FD_LSB          = 3;
  localparam int         CTRL_PL_MSB          = 2;
  localparam int         CTRL_PL_LSB          = 0;

  // Clock cycles per bit when the frequency division field is zero:
  // the output pair period then reaches its maximum of 256 clocks.
  localparam logic [8:0] FD_ZERO_DIVISOR      = 9'h080;

  // Fixed pattern that recirculates in continuous-wave mode.
  localparam logic [63:0] CW_POS_PATTERN      = 64'h5555_5555_5555_5555;
  localparam logic [63:0] CW_NEG_PATTERN      = 64'hAAAA_AAAA_AAAA_AAAA;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FIRE,
    ST_WAIT_RX,
    ST_FIRE_INV,
    ST_CW_RUN
  } state_t;

  // Pattern length in pulses for a pattern length code.
  function automatic logic [6:0] patLen(input logic [2:0] code);
    case (code)
      3'h0:    patLen = 7'h04;
      3'h1:    patLen = 7'h08;
      3'h2:    patLen = 7'h10;
      3'h3:    patLen = 7'h18;
      3'h4:    patLen = 7'h20;
      3'h5:    patLen = 7'h28;
      3'h6:    patLen = 7'h30;
      default: patLen = 7'h40;
    endcase
  endfunction

  // Number of unused low bits below a pattern of the given length.
  function automatic logic [6:0] padBits(input logic [2:0] code);
    padBits = 7'h40 - patLen(code);
  endfunction

  // Clock cycles per pattern bit for a frequency division field.
  function automatic logic [8:0] bitDivisor(input logic [6:0] fd);
    bitDivisor = (fd == 7'h00) ? FD_ZERO_DIVISOR : {2'b00, fd};
  endfunction

endpackage

// ### logic/pattern_serializer.sv
// One channel's positive and negative pattern serializer.
// Assumes the sequencer supplies load and step pulses and an emit level.
`timescale 1ns/10ps
`default_nettype none

module pattern_serializer
  import beam_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              reset,
  // Sequencer controls.
  input  wire logic              load,
  input  wire logic              step,
  input  wire logic              emit,
  input  wire logic              invert,
  input  wire logic              rotate,
  input  wire logic [6:0]        shiftAmt,
  // Patterns to load.
  input  wire logic [PAT_W-1:0]  posPattern,
  input  wire logic [PAT_W-1:0]  negPattern,
  // Pulser drive.
  output logic                   posOut,
  output logic                   negOut
);

  logic [PAT_W-1:0] posShift_ff;  // Positive bits still to go, next bit at bit 0.
  logic [PAT_W-1:0] negShift_ff;  // Negative bits still to go, next bit at bit 0.

  // Load drops the unused low bits so the first used bit sits at bit 0.
  // Rotation keeps the bits circulating for continuous-wave operation.
  always_ff @(posedge clk) begin
    if (reset) begin
      posShift_ff <= '0;
      negShift_ff <= '0;
    end else if (load) begin
      posShift_ff <= posPattern >> shiftAmt;
      negShift_ff <= negPattern >> shiftAmt;
    end else if (step && rotate) begin
      posShift_ff <= {posShift_ff[0], posShift_ff[PAT_W-1:1]};
      negShift_ff <= {negShift_ff[0], negShift_ff[PAT_W-1:1]};
    end else if (step) begin
      // Least significant bit leaves first.
      posShift_ff <= posShift_ff >> 1;
      negShift_ff <= negShift_ff >> 1;
    end
  end

  // Outputs are registered so the pulsers see clean edges; idle is low.
  always_ff @(posedge clk) begin
    if (reset) begin
      posOut <= 1'b0;
      negOut <= 1'b0;
    end else begin
      // The second firing of invert-fire sends the complement.
      posOut <= emit & (posShift_ff[0] ^ invert);
      negOut <= emit & (negShift_ff[0] ^ invert);
    end
  end

endmodule

`default_nettype wire

// ### logic/beam_pattern_top.sv
// Broadcast pattern registers, top control register and firing sequencer.
// Assumes register accesses arrive already decoded from the serial interface,
// and that clk plays the role of the pattern master clock.
//
// Notes on behaviour
// - Broadcast positive write loads every channel.
// - Broadcast negative write loads every channel.
// - Reset: positive fives in the low 48 bits, top 16 bits zero; length sixty-four pulses.
// - Reset: negative pattern is hex A digits.
// - Pattern occupies top bits matching selected length.
// - Fourteen-bit control register, PLL enabled at reset.
// - Bit twelve selects continuous-wave mode.
// - Normal mode: fire once, await next rising edge.
// - Continuous-wave: fixed pattern circulates until enable low.
// - Pattern writes ignored while continuous-wave on.
// - Bit eleven enables invert-fire mode.
// - Least significant pattern bit goes out first.
// - Invert-fire: normal, await receive, then inverted.
// - Pair period twice field clocks; zero means 256.
// - Length codes: 4, 8, 16, 24 pulses and up.
`timescale 1ns/10ps
`default_nettype none

module beam_pattern_top
  import beam_pkg::*;
#(
  parameter int NUM_CHANNELS = 8
) (
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    reset,
  // Decoded register write port.
  input  wire logic                    wrEn,
  input  wire logic [5:0]              wrAddr,
  input  wire logic [PAT_W-1:0]        wrData,
  // Decoded register read-back port.
  input  wire logic                    rdEn,
  input  wire logic [5:0]              rdAddr,
  output logic      [PAT_W-1:0]        rdData,
  // Firing control.
  input  wire logic                    txEnable,
  input  wire logic                    rxDone,
  input  wire logic                    serialLatchEnable,
  // Pulser drive and status.
  output logic      [NUM_CHANNELS-1:0] posOut,
  output logic      [NUM_CHANNELS-1:0] negOut,
  output logic                         pllEnable,
  output logic                         firingActive
);

  // The address map leaves room for eight channels only.
  if (NUM_CHANNELS < 1 || NUM_CHANNELS > MAX_CHANNELS) begin : g_bad_channels
    $error("NUM_CHANNELS must lie between 1 and 8");
  end

  // Per-channel pattern storage, aligned to the top of the 64-bit word.
  logic [PAT_W-1:0]  chanPos_ff [NUM_CHANNELS];
  logic [PAT_W-1:0]  chanNeg_ff [NUM_CHANNELS];
  // Broadcast registers keep their own copy for read-back.
  logic [PAT_W-1:0]  bcastPos_ff;
  logic [PAT_W-1:0]  bcastNeg_ff;
  // Top control register.
  logic [CTRL_W-1:0] topCtrl_ff;

  // Decoded control fields.
  logic              cwMode;       // Continuous-wave mode selected.
  logic              invertFire;   // Invert-fire mode selected.
  logic [6:0]        freqDiv;      // Frequency division field.
  logic [2:0]        lenCode;      // Pattern length code.
  logic [6:0]        padNow;       // Unused low bits at the current length.

  // Sequencer state.
  state_t            state_ff;
  logic              txPrev_ff;    // Transmit enable one cycle ago.
  logic [8:0]        divCnt_ff;    // Cycles spent on the current bit.
  logic [6:0]        bitsLeft_ff;  // Bits still to send in this firing.
  logic              invert_ff;    // Inverted second firing in progress.

  // Sequencer strobes.
  logic              txRise;       // Rising edge of transmit enable.
  logic              bitTick;      // Current bit has lasted its full width.
  logic              loadPulse;    // Serializers capture their patterns.
  logic              stepPulse;    // Serializers advance one bit.
  logic              emit;         // Serializers drive their outputs.
  logic              patWriteOk;   // Pattern writes are allowed.
  state_t            nxt_state;

  assign cwMode     = topCtrl_ff[CTRL_CW_BIT];
  assign invertFire = topCtrl_ff[CTRL_IFE_BIT];
  assign freqDiv    = topCtrl_ff[CTRL_FD_MSB:CTRL_FD_LSB];
  assign lenCode    = topCtrl_ff[CTRL_PL_MSB:CTRL_PL_LSB];
  assign padNow     = padBits(lenCode);
  assign pllEnable  = topCtrl_ff[CTRL_PLL_BIT];

  // Pattern registers are frozen in continuous-wave mode.
  assign patWriteOk = wrEn && !cwMode;

  // Per-channel registers take a direct write or a broadcast write.
  // A broadcast lands in every channel on the same edge, so no channel
  // can ever start a firing with a half-updated pattern set.
  for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan_regs
    always_ff @(posedge clk) begin
      if (reset) begin
        chanPos_ff[ch] <= POS_PATTERN_RESET;
        chanNeg_ff[ch] <= NEG_PATTERN_RESET;
      end else if (patWriteOk) begin
        // Written bits move to the top of the word.
        if (wrAddr == ADDR_BCAST_POS || wrAddr == ADDR_CHAN_POS_BASE + 6'(ch)) begin
          chanPos_ff[ch] <= wrData << padNow;
        end
        if (wrAddr == ADDR_BCAST_NEG || wrAddr == ADDR_CHAN_NEG_BASE + 6'(ch)) begin
          chanNeg_ff[ch] <= wrData << padNow;
        end
      end
    end
  end

  // Broadcast registers hold the last broadcast value for read-back.
  always_ff @(posedge clk) begin
    if (reset) begin
      bcastPos_ff <= POS_PATTERN_RESET;
      bcastNeg_ff <= NEG_PATTERN_RESET;
    end else if (patWriteOk && wrAddr == ADDR_BCAST_POS) begin
      bcastPos_ff <= wrData << padNow;
    end else if (patWriteOk && wrAddr == ADDR_BCAST_NEG) begin
      bcastNeg_ff <= wrData << padNow;
    end
  end

  // Top control register. The reserved bit is stored as zero whatever
  // software sends, so a careless write cannot leave it set.
  always_ff @(posedge clk) begin
    if (reset) begin
      topCtrl_ff <= TOP_CTRL_RESET;
    end else if (wrEn && wrAddr == ADDR_TOP_CTRL) begin
      topCtrl_ff                <= wrData[CTRL_W-1:0];
      topCtrl_ff[CTRL_RSV_BIT]  <= 1'b0;
    end
  end

  // Read-back is registered and answers one cycle after rdEn.
  // Reads have no side effects, so polling is harmless during a firing.
  // Patterns are returned right-aligned at the current length.
  always_ff @(posedge clk) begin
    if (reset) begin
      rdData <= '0;
    end else if (rdEn) begin
      if (rdAddr == ADDR_BCAST_POS) begin
        rdData <= bcastPos_ff >> padNow;
      end else if (rdAddr == ADDR_BCAST_NEG) begin
        rdData <= bcastNeg_ff >> padNow;
      end else if (rdAddr == ADDR_TOP_CTRL) begin
        rdData <= {{(PAT_W-CTRL_W){1'b0}}, topCtrl_ff};
      end else if (rdAddr >= ADDR_CHAN_POS_BASE &&
                   rdAddr <  ADDR_CHAN_POS_BASE + 6'(NUM_CHANNELS)) begin
        rdData <= chanPos_ff[3'(rdAddr - ADDR_CHAN_POS_BASE)] >> padNow;
      end else if (rdAddr >= ADDR_CHAN_NEG_BASE &&
                   rdAddr <  ADDR_CHAN_NEG_BASE + 6'(NUM_CHANNELS)) begin
        rdData <= chanNeg_ff[3'(rdAddr - ADDR_CHAN_NEG_BASE)] >> padNow;
      end else begin
        // Unmapped addresses read as zero.
        rdData <= '0;
      end
    end
  end

  // Edge detector on the firing input. The history bit resets to the
  // idle level of the pin, so an enable held high through reset is seen as a rising edge just after it.
  always_ff @(posedge clk) begin
    if (reset) begin
      txPrev_ff <= 1'b0;
    end else begin
      txPrev_ff <= txEnable;
    end
  end

  assign txRise = txEnable && !txPrev_ff;

  // Bit-width divider: each bit lasts the division field in clocks,
  // and a zero field gives the longest bit. It restarts on every load.
  // A field write in mid-firing takes effect at once; the count may then
  // run past the new end point and wrap, so that one bit comes out long.
  always_ff @(posedge clk) begin
    if (reset || loadPulse || !emit) begin
      divCnt_ff <= '0;
    end else if (bitTick) begin
      divCnt_ff <= '0;
    end else begin
      divCnt_ff <= divCnt_ff + 9'h001;
    end
  end

  assign bitTick = emit && (divCnt_ff == bitDivisor(freqDiv) - 9'h001);

  // Next-state logic of the firing sequencer.
  // A load strobe is raised only when leaving idle or the receive wait.
  always_comb begin
    nxt_state = state_ff;
    loadPulse = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (cwMode && txEnable) begin
          loadPulse = 1'b1;
          nxt_state = ST_CW_RUN;
        end else if (!cwMode && txRise) begin
          loadPulse = 1'b1;
          nxt_state = ST_FIRE;
        end
      end
      ST_FIRE: begin
        if (bitTick && bitsLeft_ff == 7'h01) begin
          // Stop after the last bit; invert-fire waits for receive.
          nxt_state = invertFire ? ST_WAIT_RX : ST_IDLE;
        end
      end
      ST_WAIT_RX: begin
        // A dropped latch enable cancels the pending inverted firing.
        if (!serialLatchEnable) begin
          nxt_state = ST_IDLE;
        end else if (rxDone) begin
          loadPulse = 1'b1;
          nxt_state = ST_FIRE_INV;
        end
      end
      ST_FIRE_INV: begin
        if (!serialLatchEnable || (bitTick && bitsLeft_ff == 7'h01)) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_CW_RUN: begin
        // Emission ends as soon as the enable drops.
        if (!txEnable) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  assign emit         = (state_ff == ST_FIRE) || (state_ff == ST_FIRE_INV) ||
                        (state_ff == ST_CW_RUN);
  assign stepPulse    = bitTick;
  assign firingActive = (state_ff != ST_IDLE);

  // Sequencer state register.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Firing length is captured at load, so a length code written during a firing
  // only affects the next one. Alignment needs no copy of its own: the
  // serializers shift the unused low bits away in the same load.
  // Continuous-wave runs never end on this count; the full word length
  // only keeps the counter in a defined state while the pattern rotates.
  always_ff @(posedge clk) begin
    if (reset) begin
      bitsLeft_ff <= 7'h40;
    end else if (loadPulse) begin
      // The last bit is the one sent while the count stands at one.
      bitsLeft_ff <= cwMode ? 7'h40 : patLen(lenCode);
    end else if (bitTick && bitsLeft_ff != 7'h01) begin
      bitsLeft_ff <= bitsLeft_ff - 7'h01;
    end
  end

  // Inversion flag covers the second firing only. It is left set after
  // that firing; emit is low then, so the stale flag never reaches a pin.
  always_ff @(posedge clk) begin
    if (reset) begin
      invert_ff <= 1'b0;
    end else if (loadPulse) begin
      invert_ff <= (state_ff == ST_WAIT_RX);
    end
  end

  // One serializer per channel; continuous-wave mode feeds the fixed
  // pattern and rotates it instead of shifting it out.
  for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_serial
    pattern_serializer u_ser (
      .clk        (clk),
      .reset      (reset),
      .load       (loadPulse),
      .step       (stepPulse),
      .emit       (emit),
      .invert     (invert_ff),
      .rotate     (state_ff == ST_CW_RUN),
      .shiftAmt   (cwMode ? 7'h00 : padNow),
      .posPattern (cwMode ? CW_POS_PATTERN : chanPos_ff[ch]),
      .negPattern (cwMode ? CW_NEG_PATTERN : chanNeg_ff[ch]),
      .posOut     (posOut[ch]),
      .negOut     (negOut[ch])
    );
  end

endmodule

`default_nettype wire

// ### tb/beam_pattern_top_sva.sv
// Checker for the broadcast pattern and top control block.
// Sees only the top ports; bound in at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module beam_pattern_top_sva
  import beam_pkg::*;
#(
  parameter int NUM_CHANNELS = 8
) (
  // Clock and reset.
  input wire logic                    clk,
  input wire logic                    reset,
  // Register ports.
  input wire logic                    wrEn,
  input wire logic [5:0]              wrAddr,
  input wire logic [PAT_W-1:0]        wrData,
  input wire logic                    rdEn,
  input wire logic [5:0]              rdAddr,
  input wire logic [PAT_W-1:0]        rdData,
  // Firing and drive.
  input wire logic                    txEnable,
  input wire logic                    rxDone,
  input wire logic                    serialLatchEnable,
  input wire logic [NUM_CHANNELS-1:0] posOut,
  input wire logic [NUM_CHANNELS-1:0] negOut,
  input wire logic                    pllEnable,
  input wire logic                    firingActive
);
  logic cwMode_ff; // Shadow of the continuous-wave bit.
  logic chanWr_ff; // Once one channel is written alone, channels may differ.
  // Track the mode bit and single-channel writes.
  always_ff @(posedge clk) begin
    if (reset) begin
      cwMode_ff <= 1'b0;
      chanWr_ff <= 1'b0;
    end else if (wrEn) begin
      if (wrAddr == ADDR_TOP_CTRL) cwMode_ff <= wrData[CTRL_CW_BIT];
      if (wrAddr < ADDR_BCAST_POS) chanWr_ff <= 1'b1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // A normal firing starts on a rising edge of the enable while idle.
  sequence fireRise_s;
    $rose(txEnable) && !firingActive && !cwMode_ff;
  endsequence
  // Idle with no new rising edge: nothing may start.
  sequence idleHold_s;
    !firingActive && !$rose(txEnable) && !cwMode_ff;
  endsequence
  rst_quiet_a: assert property (disable iff (1'b0) reset |=>
    posOut == '0 && negOut == '0 && !firingActive && pllEnable) else $error("not quiet after reset");
  fire_start_a: assert property (fireRise_s |=> firingActive)
    else $error("firing did not start");
  idle_hold_a: assert property (idleHold_s |=> !firingActive)
    else $error("fired without rising edge");
  idle_quiet_a: assert property (!firingActive && !$past(firingActive) |->
    posOut == '0 && negOut == '0) else $error("drive while idle");
  pos_same_a: assert property (!chanWr_ff |-> posOut == '0 || &posOut)
    else $error("positive channels differ");
  neg_same_a: assert property (!chanWr_ff |-> negOut == '0 || &negOut)
    else $error("negative channels differ");
  cw_run_a: assert property (cwMode_ff && txEnable && !wrEn |=> firingActive)
    else $error("continuous wave not running");
  cw_stop_a: assert property (cwMode_ff && !txEnable && firingActive |=>
    !firingActive ##1 (posOut == '0 && negOut == '0)) else $error("continuous wave did not stop");
  pll_follow_a: assert property (wrEn && wrAddr == ADDR_TOP_CTRL |=>
    pllEnable == $past(wrData[CTRL_PLL_BIT])) else $error("pll enable not stored");
  rsv_zero_a: assert property (rdEn && rdAddr == ADDR_TOP_CTRL |=>
    rdData[PAT_W-1:CTRL_RSV_BIT] == '0) else $error("control wider than 13 bits");
endmodule
bind beam_pattern_top beam_pattern_top_sva #(.NUM_CHANNELS(NUM_CHANNELS)) SVA (
  .clk(clk), .reset(reset), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .rdEn(rdEn),
  .rdAddr(rdAddr), .rdData(rdData), .txEnable(txEnable), .rxDone(rxDone),
  .serialLatchEnable(serialLatchEnable), .posOut(posOut), .negOut(negOut),
  .pllEnable(pllEnable), .firingActive(firingActive));
`default_nettype wire

// ### tb/pulser_model.sv
// Receive-only model of the channel zero pulser pair.
// Assumes the drive lines are registered and low while idle.
`timescale 1ns/10ps
`default_nettype none
module pulser_model (
  // Clock, reset and a bench clear.
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clr,
  // Drive from the beamformer.
  input  wire logic        posIn,
  input  wire logic        negIn,
  // First sixteen positive samples and pulse-cycle counts.
  output logic      [15:0] posCap,
  output logic      [15:0] posHi,
  output logic      [15:0] negHi
);
  logic       started_ff; // Capture begins at the first active sample.
  logic [4:0] idx_ff;     // Next capture slot; stops at sixteen.
  // Record what the pulser would have fired, one sample per clock.
  always_ff @(posedge clk) begin
    if (reset || clr) begin
      started_ff <= 1'b0;
      idx_ff <= 5'h00;
      posCap <= 16'h0000;
      posHi <= 16'h0000;
      negHi <= 16'h0000;
    end else begin
      posHi <= posHi + {15'h0000, posIn};
      negHi <= negHi + {15'h0000, negIn};
      // Counting alone would miss a reordered stream, hence the capture.
      if ((started_ff || posIn || negIn) && !idx_ff[4]) begin
        started_ff <= 1'b1;
        posCap[idx_ff[3:0]] <= posIn;
        idx_ff <= idx_ff + 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/broadcast_pattern_and_top_control_tb_top.sv
// Testbench for the broadcast pattern and top control block.
// Assumes the decoded register port and a pulser model on channel zero.
`timescale 1ns/10ps
`default_nettype none
module broadcast_pattern_and_top_control_tb_top
  import beam_pkg::*;
;
  logic        clk = 1'b0, reset = 1'b1, clr = 1'b0; // Clock, reset, model clear.
  logic        wrEn = 1'b0, rdEn = 1'b0, txEnable = 1'b0, rxDone = 1'b0;
  logic        serialLatchEnable = 1'b1; // The host keeps the latch line high, except for one cycle in the invert-fire cancel check.
  logic [5:0]  wrAddr = 6'h00, rdAddr = 6'h00;
  logic [63:0] wrData = 64'h0000_0000_0000_0000, rdData;
  logic [7:0]  posOut, negOut;
  logic        pllEnable, firingActive;
  logic [15:0] posCap, posHi, negHi;
  int          num_errors = 0, checks_done = 0;
  always #10 clk = ~clk; // 50 MHz.
  beam_pattern_top #(.NUM_CHANNELS(8)) DUT (.clk(clk), .reset(reset), .wrEn(wrEn),
    .wrAddr(wrAddr), .wrData(wrData), .rdEn(rdEn), .rdAddr(rdAddr), .rdData(rdData),
    .txEnable(txEnable), .rxDone(rxDone), .serialLatchEnable(serialLatchEnable),
    .posOut(posOut), .negOut(negOut), .pllEnable(pllEnable), .firingActive(firingActive));
  pulser_model PULSER (.clk(clk), .reset(reset), .clr(clr), .posIn(posOut[0]),
    .negIn(negOut[0]), .posCap(posCap), .posHi(posHi), .negHi(negHi));
  // Compare and count; case inequality so unknowns never match.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [63:0] d);
    @(posedge clk);
    wrEn <= 1'b1;
    wrAddr <= a;
    wrData <= d;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask
  // Read data lands on the edge that samples the strobe.
  task automatic rd(input logic [5:0] a, input logic [63:0] exp);
    @(posedge clk);
    rdEn <= 1'b1;
    rdAddr <= a;
    @(posedge clk);
    rdEn <= 1'b0;
    #1;
    chk(rdData, exp);
  endtask
  task automatic wrCtrl(input logic cw, input logic invert_fire_enable, input logic [6:0] fd,
                        input logic [2:0] pl);
    wr(ADDR_TOP_CTRL, {50'h0_0000_0000_0000, 1'b0, cw, invert_fire_enable, 1'b1, fd, pl});
  endtask
  task automatic clearCap();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  // Bounded wait for idle, then a few cycles for the drive to settle.
  task automatic waitIdle();
    for (int i = 0; i < 3000 && firingActive !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk(firingActive, 1'b0);
    repeat (4) @(posedge clk);
  endtask
  task automatic fire();
    @(posedge clk);
    txEnable <= 1'b1;
    repeat (2) @(posedge clk);
    waitIdle();
    txEnable <= 1'b0;
  endtask
  task automatic resetValues();
    rd(ADDR_TOP_CTRL, 64'h0000_0000_0000_047F);
    rd(ADDR_BCAST_POS, 64'h0000_5555_5555_5555);
    rd(ADDR_BCAST_NEG, 64'hAAAA_AAAA_AAAA_AAAA);
    chk(pllEnable, 1'b1);
    // Clearing the PLL bit alone must reach the pin; later writes set it again.
    wr(ADDR_TOP_CTRL, 64'h0000_0000_0000_007F);
    #1;
    chk(pllEnable, 1'b0);
  endtask
  task automatic lengthCodes();
    int lens[8] = '{4, 8, 16, 24, 32, 40, 48, 64};
    for (int k = 0; k < 8; k++) begin
      wrCtrl(1'b0, 1'b0, 7'h01, k[2:0]);
      wr(ADDR_BCAST_POS, '1);
      rd(ADDR_BCAST_POS, (lens[k] == 64) ? '1 : (64'h1 << lens[k]) - 64'h1);
    end
  endtask
  task automatic broadcastFire();
    wrCtrl(1'b0, 1'b0, 7'h01, 3'h0);
    wr(ADDR_BCAST_POS, 64'hB);
    wr(ADDR_BCAST_NEG, 64'h6);
    for (int ch = 0; ch < 8; ch++) begin
      rd(ADDR_CHAN_POS_BASE + 6'(ch), 64'hB);
      rd(ADDR_CHAN_NEG_BASE + 6'(ch), 64'h6);
    end
    clearCap();
    fire();
    chk(posCap, 16'h000B);
    chk(negHi, 16'h0002);
  endtask
  // A second rising edge mid-firing must be ignored.
  task automatic widthRefire();
    wr(ADDR_BCAST_POS, 64'h1);
    wrCtrl(1'b0, 1'b0, 7'h03, 3'h0);
    clearCap();
    @(posedge clk);
    txEnable <= 1'b1;
    repeat (4) @(posedge clk);
    txEnable <= 1'b0;
    @(posedge clk);
    txEnable <= 1'b1;
    waitIdle();
    txEnable <= 1'b0;
    chk(posHi, 16'h0003);
    fire();
    chk(posHi, 16'h0006);
    wrCtrl(1'b0, 1'b0, 7'h00, 3'h0);
    clearCap();
    fire();
    chk(posHi, 16'h0080);
  endtask
  task automatic invertFire();
    wr(ADDR_BCAST_POS, 64'hB);
    wrCtrl(1'b0, 1'b1, 7'h01, 3'h0);
    clearCap();
    @(posedge clk);
    txEnable <= 1'b1;
    repeat (12) @(posedge clk);
    #1;
    chk(posHi, 16'h0003);
    chk(firingActive, 1'b1);
    @(posedge clk);
    rxDone <= 1'b1;
    @(posedge clk);
    rxDone <= 1'b0;
    waitIdle();
    txEnable <= 1'b0;
    chk(posHi, 16'h0004);
    chk(negHi, 16'h0004);
    // Dropping the latch line in the receive wait abandons the second firing.
    @(posedge clk);
    txEnable <= 1'b1;
    repeat (12) @(posedge clk);
    serialLatchEnable <= 1'b0;
    @(posedge clk);
    serialLatchEnable <= 1'b1;
    txEnable <= 1'b0;
    @(posedge clk);
    #1;
    chk(firingActive, 1'b0);
  endtask
  // Pattern writes in this mode must not reach the stored patterns.
  task automatic cwMode();
    wrCtrl(1'b1, 1'b0, 7'h01, 3'h0);
    wr(ADDR_BCAST_POS, 64'hF);
    wr(ADDR_CHAN_POS_BASE, 64'h0);
    clearCap();
    @(posedge clk);
    txEnable <= 1'b1;
    repeat (40) @(posedge clk);
    #1;
    chk(firingActive, 1'b1);
    chk(posCap, 16'h5555);
    @(posedge clk);
    txEnable <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(posOut, 8'h00);
    wrCtrl(1'b0, 1'b0, 7'h01, 3'h0);
    rd(ADDR_BCAST_POS, 64'hB);
    rd(ADDR_CHAN_POS_BASE, 64'hB);
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    resetValues();
    lengthCodes();
    broadcastFire();
    widthRefire();
    invertFire();
    cwMode();
    summarize();
  end
  // The tests need under 1000 cycles; 20000 leaves a wide margin.
  initial begin
    #400000;
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
